/* inc/bcs_pkg.sv */
// package for the battery charge state controller
// assumes a single 20 MHz system clock; oscillator period arrives as a pulse
package bcs_pkg;
  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned POR_TIME_US = 200;
  // power-on hold, rounded up to whole cycles
  localparam int unsigned POR_CYCLES = (POR_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned POR_CNT_W = 13;
  // safety counter stages and trickle fraction (1/8 = 3 stages fewer)
  localparam int unsigned SAFETY_STAGES = 22;
  localparam int unsigned TRICKLE_SHIFT = 3;
  // consecutive periods above trickle threshold before leaving trickle
  localparam logic [3:0] TRICKLE_DEBOUNCE = 4'hf;
  // number of synchronised analog flags
  localparam int unsigned FLAG_N = 7;
  localparam int unsigned FLAG_TRICKLE = 0;
  localparam int unsigned FLAG_TERM = 1;
  localparam int unsigned FLAG_END_CURRENT_PROGRAM = 2;
  localparam int unsigned FLAG_COLD = 3;
  localparam int unsigned FLAG_HOT = 4;
  localparam int unsigned FLAG_REMOVED = 5;
  localparam int unsigned FLAG_RECHARGE = 6;
  // ****************************************
  // states
  // ****************************************
  typedef enum logic [7:0] {
    ST_POR      = 8'h01,
    ST_TRICKLE  = 8'h02,
    ST_CC       = 8'h04,
    ST_CV       = 8'h08,
    ST_INHIBIT  = 8'h10,
    ST_FAULT    = 8'h20,
    ST_STANDBY  = 8'h40,
    ST_TEMPWAIT = 8'h80
  } bcs_state_t;
  // current command levels
  typedef enum logic [1:0] {
    CUR_OFF = 2'h0,
    CUR_TENTH = 2'h1,
    CUR_FULL = 2'h2
  } bcs_cur_t;
endpackage

/* test/bcs_batt_model.sv */
// battery and comparator model facing the sequencer
// assumes the bench may pin the cell level; it rises with charge current otherwise
module bcs_batt_model #(
  parameter int unsigned DIV = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // charger command and bench hold
  input wire logic [1:0] current_cmd,
  input wire logic set_en,
  input wire logic [7:0] set_lvl,
  // oscillator and flags
  output logic osc_tick,
  output logic above_trickle_threshold,
  output logic at_termination_voltage,
  output logic below_end_current,
  output logic below_recharge_threshold
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] lvl_q;
  logic [7:0] lvl_d;
  logic [3:0] div_q;
  // any current climbs four steps a period below termination, one above; caps at full
  assign lvl_d = set_en ? set_lvl : (!osc_tick || current_cmd == bcs_pkg::CUR_OFF ||
    lvl_q >= 8'h78) ? lvl_q : lvl_q + ((lvl_q < 8'h64) ? 8'h04 : 8'h01);
  assign osc_tick = (div_q == 4'h0);
  assign above_trickle_threshold = (lvl_q >= 8'h1e);
  assign at_termination_voltage = (lvl_q >= 8'h64);
  assign below_end_current = (lvl_q >= 8'h78);
  assign below_recharge_threshold = (lvl_q < 8'h5a);
  // free-running oscillator; it never stops
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_q <= 4'h0;
      lvl_q <= 8'h00;
    end else begin
      div_q <= (div_q == 4'(DIV - 1)) ? 4'h0 : div_q + 4'h1;
      lvl_q <= lvl_d;
    end
  end
endmodule

/* test/bcs_checker_assertions.sv */
// port-level checks on the charge sequencer
// assumes one clock domain; bound to every sequencer instance below
module bcs_checker #(
  parameter int unsigned POR_CYCLES = 10,
  parameter int unsigned STAGES = 22
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // pins and flags
  input wire logic adapter_supply,
  input wire logic charge_enable,
  input wire logic osc_tick,
  input wire logic above_trickle_threshold,
  input wire logic below_cold_threshold,
  input wire logic above_hot_threshold,
  input wire logic battery_removed,
  // outputs watched
  input wire logic fault_out,
  input wire logic fault_oe,
  input wire logic status_out,
  input wire logic status_oe,
  input wire logic [1:0] current_cmd,
  input wire logic reference_presence_out,
  input wire logic timeout_latched
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // periods seen above threshold while trickling; one tick of slack for sync skew
  logic [4:0] hi_q;
  logic [4:0] hi_d;
  assign hi_d = (!above_trickle_threshold || current_cmd != bcs_pkg::CUR_TENTH) ? 5'h00 :
    (osc_tick && hi_q != 5'h1f) ? hi_q + 5'h01 : hi_q;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) hi_q <= 5'h00;
    else hi_q <= hi_d;
  end
  sequence s_left_trickle;
    current_cmd == bcs_pkg::CUR_TENTH ##1 current_cmd == bcs_pkg::CUR_FULL;
  endsequence
  property p_debounce; s_left_trickle |-> hi_q >= 5'h0e; endproperty
  a_debounce: assert property (p_debounce) else $error("trickle left early");
  property p_por; $fell(sys_rst) |-> (fault_oe && !status_oe) [*8]; endproperty
  a_por: assert property (p_por) else $error("power-on indication wrong");
  property p_od; fault_out == 1'b0 && status_out == 1'b0 && !(fault_oe && status_oe); endproperty
  a_od: assert property (p_od) else $error("indicator encoding wrong");
  property p_tenth; current_cmd == bcs_pkg::CUR_TENTH |-> status_oe && !fault_oe; endproperty
  a_tenth: assert property (p_tenth) else $error("trickle indication wrong");
  property p_latch;
    $rose(timeout_latched) |-> ##[0:1] (fault_oe && !status_oe && current_cmd == bcs_pkg::CUR_OFF);
  endproperty
  a_latch: assert property (p_latch) else $error("timeout not shown");
  property p_hold;
    (timeout_latched && charge_enable && adapter_supply) [*6] |=> timeout_latched;
  endproperty
  a_hold: assert property (p_hold) else $error("timeout latch dropped");
  property p_adapter;
    !adapter_supply [*8] |-> !reference_presence_out && current_cmd == bcs_pkg::CUR_OFF;
  endproperty
  a_adapter: assert property (p_adapter) else $error("charging without supply");
  property p_enable; !charge_enable [*8] |-> current_cmd == bcs_pkg::CUR_OFF && !status_oe; endproperty
  a_enable: assert property (p_enable) else $error("charging while disabled");
  property p_temp;
    (above_hot_threshold || below_cold_threshold || battery_removed) [*8] |->
      current_cmd == bcs_pkg::CUR_OFF;
  endproperty
  a_temp: assert property (p_temp) else $error("charging out of window");
endmodule
bind bcs_charge_ctrl bcs_checker #(.POR_CYCLES(POR_CYCLES), .STAGES(STAGES)) bcs_checker_i (
  .clk, .sys_rst, .adapter_supply, .charge_enable, .osc_tick, .above_trickle_threshold,
  .below_cold_threshold, .above_hot_threshold, .battery_removed, .fault_out, .fault_oe,
  .status_out, .status_oe, .current_cmd, .reference_presence_out, .timeout_latched);

/* test/tb.sv */
// self-checking bench for the charge sequencer
// assumes the battery model supplies ticks and voltage flags
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, sys_rst, adapter_supply, charge_enable, time_limit_enable, set_en;
  logic below_cold_threshold, above_hot_threshold, battery_removed, osc_tick;
  logic above_trickle_threshold, at_termination_voltage, below_end_current;
  logic below_recharge_threshold, fault_out, fault_oe, status_out, status_oe;
  logic voltage_loop_en, reference_presence_out, timeout_latched;
  logic [1:0] current_cmd;
  logic [7:0] set_lvl;
  int n_errors = 0;
  int compares = 0;
  // open-drain pins with their external pull-ups
  wire fault_pin = fault_oe ? fault_out : 1'b1;
  wire status_pin = status_oe ? status_out : 1'b1;
  localparam logic [3:0] IND_TRICKLE = {2'h2, bcs_pkg::CUR_TENTH};
  localparam logic [3:0] IND_FAST = {2'h2, bcs_pkg::CUR_FULL};
  localparam logic [3:0] IND_FAULT = {2'h1, bcs_pkg::CUR_OFF};
  localparam logic [3:0] IND_IDLE = {2'h3, bcs_pkg::CUR_OFF};
  // short counts keep the run brief: eighth span is 32 periods, full 256
  bcs_charge_ctrl #(.POR_CYCLES(10), .STAGES(8)) bcs_charge_ctrl_i (
    .clk, .sys_rst, .adapter_supply, .charge_enable, .time_limit_enable, .osc_tick,
    .above_trickle_threshold, .at_termination_voltage, .below_end_current,
    .below_cold_threshold, .above_hot_threshold, .battery_removed,
    .below_recharge_threshold, .fault_out, .fault_oe, .status_out, .status_oe,
    .current_cmd, .voltage_loop_en, .reference_presence_out, .timeout_latched);
  bcs_batt_model #(.DIV(4)) bcs_batt_model_i (
    .clk, .sys_rst, .current_cmd, .set_en, .set_lvl, .osc_tick, .above_trickle_threshold,
    .at_termination_voltage, .below_end_current, .below_recharge_threshold);
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic ticks(input int n);
    repeat (n) @(posedge clk iff osc_tick == 1'b1);
    #1;
  endtask
  // waits a bounded number of cycles for an indication, then compares
  task automatic wait_ind(input string what, input logic [3:0] e, input int lim);
    int k;
    k = 0;
    while ({fault_pin, status_pin, current_cmd} !== e && k < lim) begin
      cyc(1);
      k++;
    end
    chk(what, {4'h0, fault_pin, status_pin, current_cmd}, {4'h0, e});
  endtask
  task automatic wrap_up();
    if (n_errors == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    // limit input left high, as its pull-up would leave it
    {sys_rst, adapter_supply, charge_enable, time_limit_enable, set_en} = 5'h1f;
    {below_cold_threshold, above_hot_threshold, battery_removed} = 3'h0;
    set_lvl = 8'h1f;
    cyc(2);
    wait_ind("reset ind", IND_FAULT, 0);
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    cyc(5);
    wait_ind("por hold", IND_FAULT, 0);
    wait_ind("start", IND_TRICKLE, 40);
    chk("ref", reference_presence_out, 8'h01);
    chk("loop off", voltage_loop_en, 8'h00);
    ticks(13);
    wait_ind("debounce", IND_TRICKLE, 0);
    wait_ind("cc", IND_FAST, 20);
    chk("loop on", voltage_loop_en, 8'h01);
    @(posedge clk);
    set_en <= 1'b0;
    wait_ind("done", IND_IDLE, 400);
    @(posedge clk);
    {set_en, time_limit_enable} <= 2'h2;
    set_lvl <= 8'h0a;
    wait_ind("recharge", IND_TRICKLE, 20);
    // the 32nd period is at least four cycles away, so trickle must still run
    ticks(31);
    cyc(3);
    wait_ind("trickle run", IND_TRICKLE, 0);
    wait_ind("trickle limit", IND_FAULT, 40);
    chk("latch", timeout_latched, 8'h01);
    @(posedge clk);
    set_lvl <= 8'h1f;
    cyc(40);
    wait_ind("latched", IND_FAULT, 0);
    @(posedge clk);
    charge_enable <= 1'b0;
    wait_ind("standby", IND_IDLE, 20);
    cyc(10);
    wait_ind("standby hold", IND_IDLE, 0);
    @(posedge clk);
    charge_enable <= 1'b1;
    wait_ind("enable rise", IND_TRICKLE, 20);
    chk("unlatch", timeout_latched, 8'h00);
    wait_ind("no limit", IND_FAST, 80);
    ticks(300);
    wait_ind("long cc", IND_FAST, 0);
    @(posedge clk);
    time_limit_enable <= 1'b1;
    wait_ind("fast limit", IND_FAULT, 1100);
    @(posedge clk);
    adapter_supply <= 1'b0;
    cyc(10);
    chk("ref off", reference_presence_out, 8'h00);
    chk("off cur", current_cmd, bcs_pkg::CUR_OFF);
    chk("power unlatch", timeout_latched, 8'h00);
    @(posedge clk);
    adapter_supply <= 1'b1;
    wait_ind("replug", IND_TRICKLE, 40);
    // hot, cold, then removal, each cleared again
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      {battery_removed, below_cold_threshold, above_hot_threshold} <= 3'h1 << i;
      wait_ind("temp fault", IND_FAULT, 20);
      cyc(10);
      wait_ind("temp hold", IND_FAULT, 0);
      chk("no latch", timeout_latched, 8'h00);
      @(posedge clk);
      {battery_removed, below_cold_threshold, above_hot_threshold} <= 3'h0;
      wait_ind("temp clear", IND_TRICKLE, 20);
    end
    wrap_up();
  end
  // hang guard, well beyond the expected few thousand cycles
  initial begin
    cyc(20000);
    n_errors++;
    wrap_up();
  end
endmodule

/* verilog/bcs_charge_ctrl.sv */
// charge state sequencer for a single-cell linear charger
// assumes analog comparators deliver async flags and an oscillator tick pulse
// Function
// RULE_01 - safety counter advances once per oscillator period, full span 2^22
// RULE_02 - timeout fault when fast charge exceeds full or trickle exceeds eighth
// RULE_03 - low time-limit enable disables fast-charge limit; floating keeps it
// RULE_04 - trickle eighth limit always enforced regardless of enable input
// RULE_05 - timeout fault latches until power cycle or enable toggle
// RULE_06 - standby while adapter absent or enable low; adapter absent holds the power-on state instead
// RULE_07 - stop charging outside thermistor window, restart cycle when inside
// RULE_08 - thermistor at removal level means battery gone: fault and halt
// RULE_09 - power-on reset about 200 us, status high, fault low
// RULE_10 - after reset charge cycle runs trickle, constant current, constant voltage
// RULE_11 - fault-free completion enters inhibit awaiting discharge
// RULE_12 - timeout or temperature fault in charge mode enters fault state
// RULE_13 - indicators: both high idle, status low charging, fault low fault
// RULE_14 - new cycle on adapter, insertion, recharge, temp clear, enable rise
// RULE_15 - below trickle threshold command one tenth of programmed current
// RULE_16 - leave trickle after fifteen consecutive periods above threshold
// RULE_17 - clear counter entering constant current, end at termination voltage
// RULE_18 - reference presence output only while supply above reset threshold
// RULE_19 - constant voltage completes when minimum-current flag asserts
// RULE_20 - constant current plus constant voltage time limited when enabled
// RULE_21 - inhibit watches recharge flag and restarts below threshold
// RULE_22 - temperature fault does not latch; restart when condition clears
// RULE_23 - all comparator flags synchronised before use
// RULE_24 - safety counter also cleared entering trickle at cycle start
module bcs_charge_ctrl #(
  parameter int unsigned POR_CYCLES = bcs_pkg::POR_CYCLES,
  parameter int unsigned STAGES = bcs_pkg::SAFETY_STAGES
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // supply and pins
  input wire logic adapter_supply,
  input wire logic charge_enable,
  input wire logic time_limit_enable,
  input wire logic osc_tick,
  // comparator flags, asynchronous
  input wire logic above_trickle_threshold,
  input wire logic at_termination_voltage,
  input wire logic below_end_current,
  input wire logic below_cold_threshold,
  input wire logic above_hot_threshold,
  input wire logic battery_removed,
  input wire logic below_recharge_threshold,
  // open-drain indicators
  output logic fault_out,
  output logic fault_oe,
  output logic status_out,
  output logic status_oe,
  // analog loop and system
  output logic [1:0] current_cmd,
  output logic voltage_loop_en,
  output logic reference_presence_out,
  output logic timeout_latched
);
  // ****************************************
  // input synchronisation
  // ****************************************
  logic [bcs_pkg::FLAG_N-1:0] flags_raw;
  logic [bcs_pkg::FLAG_N-1:0] flags;
  logic [2:0] pins_s;
  logic adapter_s;
  logic enable_s;
  logic time_limit_enable_s;
  assign flags_raw = {below_recharge_threshold, battery_removed, above_hot_threshold,
                      below_cold_threshold, below_end_current, at_termination_voltage,
                      above_trickle_threshold};
  // RULE_23 sync comparator flags
  bcs_sync #(.WIDTH(bcs_pkg::FLAG_N)) u_flag_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .async_in(flags_raw),
    .sync_out(flags)
  );
  // pins come from outside the clock domain too
  // three flops each; a level counts once the last two stages agree
  bcs_sync #(.WIDTH(3)) u_pin_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .async_in({time_limit_enable, charge_enable, adapter_supply}),
    .sync_out(pins_s)
  );
  assign adapter_s = pins_s[0];
  assign enable_s = pins_s[1];
  assign time_limit_enable_s = pins_s[2];

  // ****************************************
  // decoded conditions
  // ****************************************
  logic f_trickle_ok;
  logic f_term;
  logic f_end_current_program;
  logic f_removed;
  logic f_recharge;
  logic temp_bad;
  logic active;
  assign f_trickle_ok = flags[bcs_pkg::FLAG_TRICKLE];
  assign f_term = flags[bcs_pkg::FLAG_TERM];
  assign f_end_current_program = flags[bcs_pkg::FLAG_END_CURRENT_PROGRAM];
  assign f_removed = flags[bcs_pkg::FLAG_REMOVED];
  assign f_recharge = flags[bcs_pkg::FLAG_RECHARGE];
  // removal sits above the window, so it stops charging like a window fault
  // RULE_07 window check
  assign temp_bad = flags[bcs_pkg::FLAG_COLD] || flags[bcs_pkg::FLAG_HOT] || f_removed;
  // RULE_06 standby condition
  assign active = adapter_s && enable_s;

  // ****************************************
  // state names
  // ****************************************
  // local copies of the package codes keep the case items short
  localparam bcs_pkg::bcs_state_t ST_POR = bcs_pkg::ST_POR;
  localparam bcs_pkg::bcs_state_t ST_TRICKLE = bcs_pkg::ST_TRICKLE;
  localparam bcs_pkg::bcs_state_t ST_CC = bcs_pkg::ST_CC;
  localparam bcs_pkg::bcs_state_t ST_CV = bcs_pkg::ST_CV;
  localparam bcs_pkg::bcs_state_t ST_INHIBIT = bcs_pkg::ST_INHIBIT;
  localparam bcs_pkg::bcs_state_t ST_FAULT = bcs_pkg::ST_FAULT;
  localparam bcs_pkg::bcs_state_t ST_STANDBY = bcs_pkg::ST_STANDBY;
  localparam bcs_pkg::bcs_state_t ST_TEMPWAIT = bcs_pkg::ST_TEMPWAIT;
  // true in any of the three charge modes; used on current and next state
  function automatic logic is_charging(input bcs_pkg::bcs_state_t s);
    is_charging = (s == ST_TRICKLE) || (s == ST_CC) || (s == ST_CV);
  endfunction

  // ****************************************
  // state registers
  // ****************************************
  // an upset one-hot code falls back to the power-on state, or to standby while the adapter is present and enable is low
  bcs_pkg::bcs_state_t state_q;
  bcs_pkg::bcs_state_t state_d;
  logic [bcs_pkg::POR_CNT_W-1:0] por_q;
  logic [bcs_pkg::POR_CNT_W-1:0] por_d;
  logic [3:0] deb_q;
  logic [3:0] deb_d;
  logic latch_q;
  logic latch_d;
  logic enable_prev_q;
  logic adapter_prev_q;
  logic enable_rise;
  logic adapter_rise;
  logic timer_clear;
  logic timer_run;
  logic full_exp;
  logic eighth_exp;
  logic fast_timeout;
  logic por_done;

  // edge detectors read only the settled synchroniser outputs
  // both reset low, so a pin high at power-up reads as one rise in the hold
  assign enable_rise = enable_s && !enable_prev_q;
  assign adapter_rise = adapter_s && !adapter_prev_q;
  assign por_done = (por_q == bcs_pkg::POR_CNT_W'(POR_CYCLES - 1));
  // supply loss restarts the hold, so a brownout replays the power-on phase
  // RULE_09 power-on hold count
  assign por_d = (!adapter_s) ? '0 : (por_done ? por_q : por_q + 1'b1);

  // trickle never looks at the pin: only the eighth limit applies there
  // RULE_03 fast limit gated by enable
  // RULE_20 cc plus cv share one count
  assign fast_timeout = full_exp && time_limit_enable_s;

  // RULE_01 safety timer instance
  bcs_safety_timer #(.STAGES(STAGES), .SHIFT(bcs_pkg::TRICKLE_SHIFT)) u_timer (
    .clk(clk),
    .sys_rst(sys_rst),
    .osc_tick(osc_tick),
    .clear(timer_clear),
    .run(timer_run),
    .full_expired(full_exp),
    .eighth_expired(eighth_exp)
  );
  // counter holds outside the charge modes; every entry clears it anyway
  assign timer_run = is_charging(state_q);
  // RULE_24 clear on entry to trickle
  // RULE_17 clear on entry to cc
  assign timer_clear = ((state_d == ST_TRICKLE) && (state_q != ST_TRICKLE)) ||
                       ((state_d == ST_CC) && (state_q != ST_CC));

  // one low period or any other state drops the count back to zero
  // RULE_16 debounce of trickle exit
  assign deb_d = (state_q != ST_TRICKLE || !f_trickle_ok) ? 4'h0 :
                 (osc_tick && deb_q != bcs_pkg::TRICKLE_DEBOUNCE) ? deb_q + 4'h1 : deb_q;

  // setting wins over a release that falls in the same cycle
  // a temperature fault never sets it, so a thermistor event cannot latch
  // RULE_05 latch set on timeout, released by power loss or enable rise
  assign latch_d = (state_d == ST_FAULT && !temp_bad) ? 1'b1 :
                   (!adapter_s || enable_rise) ? 1'b0 : latch_q;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_POR: begin
        // RULE_10 charge right after reset
        if (!adapter_s) state_d = ST_POR;
        else if (por_done) state_d = enable_s ? ST_TRICKLE : ST_STANDBY;
      end
      ST_TRICKLE, ST_CC, ST_CV: begin
        // RULE_12 faults in charge modes
        // RULE_08 removal halts charging
        if (temp_bad) state_d = ST_TEMPWAIT;
        // RULE_04 trickle limit always on
        // RULE_02 timeout fault
        else if (state_q == ST_TRICKLE && eighth_exp) state_d = ST_FAULT;
        else if (state_q != ST_TRICKLE && fast_timeout) state_d = ST_FAULT;
        else if (state_q == ST_TRICKLE && deb_q == bcs_pkg::TRICKLE_DEBOUNCE) state_d = ST_CC;
        // RULE_17 end cc at termination
        else if (state_q == ST_CC && f_term) state_d = ST_CV;
        // RULE_19 finish on minimum current
        // RULE_11 to inhibit
        else if (state_q == ST_CV && f_end_current_program) state_d = ST_INHIBIT;
      end
      ST_INHIBIT: begin
        // RULE_21 recharge restart
        if (f_recharge) state_d = ST_TRICKLE;
      end
      ST_TEMPWAIT: begin
        // window and removal faults never latch; no release is needed
        // RULE_22 restart once temperature clears
        if (!temp_bad) state_d = ST_TRICKLE;
      end
      ST_FAULT: begin
        // latched until released
        if (!latch_q) state_d = ST_TRICKLE;
      end
      ST_STANDBY: begin
        // RULE_14 enable rise; adapter return comes back through the power-on hold
        if (active) state_d = ST_TRICKLE;
      end
      default: state_d = ST_POR;
    endcase
    // supply loss outranks everything, and standby outranks faults as well
    // RULE_06 standby overrides, but power loss goes back through reset
    if (state_q != ST_POR) begin
      if (!adapter_s) state_d = ST_POR;
      else if (!enable_s) state_d = ST_STANDBY;
      else if (state_q == ST_FAULT && enable_rise) state_d = ST_TRICKLE;
    end
  end

  // ****************************************
  // output decode
  // ****************************************
  logic charging_d;
  logic fault_ind_d;
  logic [1:0] cur_d;
  // status pin pulled low in every charge mode
  assign charging_d = is_charging(state_d);
  // temp wait shows fault for removal and for window faults alike
  assign fault_ind_d = (state_d == ST_POR) || (state_d == ST_FAULT) || (state_d == ST_TEMPWAIT);
  // RULE_15 tenth current in trickle
  assign cur_d = (state_d == ST_TRICKLE) ? bcs_pkg::CUR_TENTH :
                 (state_d == ST_CC || state_d == ST_CV) ? bcs_pkg::CUR_FULL : bcs_pkg::CUR_OFF;

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= ST_POR;
      por_q <= '0;
      deb_q <= 4'h0;
      latch_q <= 1'b0;
      enable_prev_q <= 1'b0;
      adapter_prev_q <= 1'b0;
    end else begin
      state_q <= state_d;
      por_q <= por_d;
      deb_q <= deb_d;
      latch_q <= latch_d;
      enable_prev_q <= enable_s;
      adapter_prev_q <= adapter_s;
    end
  end

  // RULE_13 indicator encoding
  // RULE_09 status high, fault low during reset
  // RULE_18 presence follows supply
  // open-drain data bits stay low; only the enables move the pins
  // decoding the next state keeps every output one flop from its cause
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fault_out <= 1'b0;
      fault_oe <= 1'b1;
      status_out <= 1'b0;
      status_oe <= 1'b0;
      current_cmd <= bcs_pkg::CUR_OFF;
      voltage_loop_en <= 1'b0;
      reference_presence_out <= 1'b0;
      timeout_latched <= 1'b0;
    end else begin
      fault_out <= 1'b0;
      fault_oe <= fault_ind_d;
      status_out <= 1'b0;
      status_oe <= charging_d;
      current_cmd <= cur_d;
      voltage_loop_en <= (state_d == ST_CC) || (state_d == ST_CV);
      reference_presence_out <= adapter_s || adapter_rise;
      timeout_latched <= latch_d;
    end
  end
endmodule

/* verilog/bcs_safety_timer.sv */
// safety counter advanced once per oscillator period
// assumes osc_tick is a one-cycle pulse already in the clk domain
module bcs_safety_timer #(
  parameter int unsigned STAGES = 22,
  parameter int unsigned SHIFT = 3
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // control
  input wire logic osc_tick,
  input wire logic clear,
  input wire logic run,
  // expiry flags
  output logic full_expired,
  output logic eighth_expired
);
  logic [STAGES-1:0] cnt_q;
  logic [STAGES-1:0] cnt_d;
  logic at_top;
  logic wrap_d;
  logic eighth_d;
  // count stops at all ones; the tick that would wrap it marks the full span
  assign at_top = (cnt_q == {STAGES{1'b1}});
  assign wrap_d = at_top && run && osc_tick;
  // an eighth has passed once any of the top stages is set
  assign eighth_d = (cnt_q[STAGES-1:STAGES-SHIFT] != '0);
  assign cnt_d = clear ? '0 :
                 (run && osc_tick && !at_top) ? cnt_q + 1'b1 : cnt_q;
  // ****************************************
  // counter
  // ****************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= '0;
      full_expired <= 1'b0;
      eighth_expired <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      full_expired <= !clear && (full_expired || wrap_d);
      eighth_expired <= eighth_d && !clear;
    end
  end
endmodule

/* verilog/bcs_sync.sv */
// three-flop synchroniser bank for asynchronous comparator flags
// assumes flags are slow levels; a change counts once stages two and three agree
module bcs_sync #(
  parameter int unsigned WIDTH = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // async in, filtered out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] out_d;
  // output only moves when the last two stages agree
  assign out_d = (s2_q == s3_q) ? s3_q : sync_out;
  // ****************************************
  // shift chain
  // ****************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      sync_out <= '0;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      sync_out <= out_d;
    end
  end
endmodule
